// [hw/atss_pkg.sv]
package atss_pkg;

    // register word indices; byte address is four times the index
    localparam logic [31:0] ATSS_IDX_CONFIG   = 32'h4000_1058;
    localparam logic [31:0] ATSS_IDX_CHANNEL  = 32'h4000_1059;
    localparam logic [31:0] ATSS_IDX_CONTROL  = 32'h4000_105A;
    localparam logic [31:0] ATSS_IDX_IRQFLAG  = 32'h4000_105B;
    localparam logic [31:0] ATSS_IDX_RESULT   = 32'h4000_105C;
    localparam logic [31:0] ATSS_IDX_THERMAL  = 32'h4000_105D;
    localparam logic [31:0] ATSS_IDX_CHGCOUNT = 32'h4000_105F;

    // control, flag and thermal register bit positions
    localparam int ATSS_BIT_GO       = 0;
    localparam int ATSS_BIT_TKPWR    = 3;
    localparam int ATSS_BIT_BUSY     = 4;
    localparam int ATSS_BIT_CHARGING = 5;
    localparam int ATSS_BIT_END      = 7;
    localparam int ATSS_BIT_IRQ      = 7;
    localparam int ATSS_BIT_THPWR    = 7;

    // reset values
    localparam logic [7:0] ATSS_RST_CONFIG  = 8'h20;
    localparam logic [7:0] ATSS_RST_CONTROL = 8'h00;
    localparam logic [7:0] ATSS_RST_CHGCNT  = 8'h00;
    localparam logic [3:0] ATSS_RST_CHANNEL = 4'h0;

    // timing, in converter clocks or system clocks
    localparam logic [7:0] ATSS_SAMPLE_CLKS = 8'h04;
    localparam logic [7:0] ATSS_CONV_CLKS   = 8'h0C;
    localparam logic [7:0] ATSS_GAP_CLKS    = 8'h01;
    localparam logic [7:0] ATSS_DISCH_SHORT = 8'h08;
    localparam logic [7:0] ATSS_DISCH_LONG  = 8'h0E;
    localparam logic [7:0] ATSS_CHG_LONG_AT = 8'h80;
    localparam logic [2:0] ATSS_DIV_ZERO_AS = 3'h4;

    // channel routing constants
    localparam logic [3:0] ATSS_CH_TEMP    = 4'hF;
    localparam logic [3:0] ATSS_AIN_ZERO   = 4'h0;
    localparam logic [3:0] ATSS_AIN_ONE    = 4'h1;
    localparam logic [3:0] ATSS_AIN_TWO    = 4'h2;
    localparam logic [3:0] ATSS_AIN_THREE  = 4'h3;
    localparam logic [11:0] ATSS_DIFF_MID  = 12'h800;

    // converter configuration fields
    typedef struct packed {
        logic [1:0] clkDiv;
        logic [1:0] gain;
        logic       testMode;
        logic       diffSel;
        logic       bufEn;
        logic       power;
    } atss_cfg_s;

    // controls towards the analog front end and electrodes
    typedef struct packed {
        logic [3:0] posSel;
        logic [3:0] negSel;
        logic       diffSel;
        logic       tempSel;
        logic       power;
        logic       bufEn;
        logic [1:0] gain;
        logic       thermPower;
        logic       sample;
        logic       convert;
        logic       charge;
        logic       discharge;
    } atss_ana_s;

    // sequencer states
    typedef enum logic [5:0] {
        ST_IDLE   = 6'b000001,
        ST_CHARGE = 6'b000010,
        ST_DISCH  = 6'b000100,
        ST_SAMPLE = 6'b001000,
        ST_CONV   = 6'b010000,
        ST_GAP    = 6'b100000
    } atss_state_e;

endpackage : atss_pkg

// [hw/atss_sequencer.sv]
// Notes on behaviour
// R1 - start bit begins, reads one, self-clears
// R2 - four sample clocks, then twelve conversion
// R3 - one extra clock between back-to-back conversions
// R4 - converter clock is system clock divided by divider
// R5 - differential channel 0: input zero minus two
// R6 - differential channel 1: input one minus three
// R7 - differential result offset-coded around 0x800
// R8 - 12-bit result stored in result register
// R9 - channel 15 routes temperature sensor
// R10 - touch and conversion control share one register
// R11 - status bit 5 shows capacitor charging
// R12 - status bit 4 shows touch measurement busy
// R13 - control bit 3 enables touch engine
// R14 - control bit 7 shows conversion ended
// R15 - charge count is 8-bit system clocks
// R16 - discharge 8 clocks below 128, else 14
// R17 - writing charge count starts touch measurement
// R18 - software should program charge count >= 0x10
// R19 - control write clears end-of-conversion flag
// R20 - completion sets end-of-conversion flag
// R21 - software selects channel, starts, waits, repeats
// R22 - flag in bit 7 of own register
// R23 - touch phases charge, discharge, convert in order
//
// Local design decision: register access over Avalon-MM.
`timescale 1ns/1ps
module atss_sequencer
    import atss_pkg::*;
(
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        reset,
    // avalon-mm slave
    input  wire logic [31:0] avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // converter data from the analog front end
    input  wire logic [11:0] anaData,
    // analog front end and electrode controls
    output atss_ana_s        anaCtrl
);

    ////////////////////////////////////////////////////////////////////////
    // state and registers
    atss_state_e state_r, stateNxt;
    atss_cfg_s   cfg_r;
    logic [3:0]  chan_r;
    logic        therm_r;
    logic        goBit_r, goNxt;
    logic        tkEn_r;
    logic        convEnd_r;
    logic        irqFlag_r;
    logic [7:0]  chgCnt_r;
    logic        touchPend_r, touchRun_r;
    logic [11:0] result_r;
    logic [11:0] dataSync1_r, dataSync2_r;
    logic [7:0]  phCnt_r, phCntNxt;
    logic [2:0]  divCnt_r;
    logic        waitReq_r;
    logic [31:0] rdData_r;
    atss_ana_s   ana_r, anaNxt;

    ////////////////////////////////////////////////////////////////////////
    // bus decode
    wire         req      = avs_read | avs_write;
    wire         acc      = req & ~waitReq_r;
    wire         wrLane   = avs_write & acc & avs_byteenable[0];
    wire  [7:0]  wByte    = avs_writedata[7:0];
    wire         selCfg   = avs_address == ATSS_IDX_CONFIG;
    wire         selChan  = avs_address == ATSS_IDX_CHANNEL;
    wire         selCtrl  = avs_address == ATSS_IDX_CONTROL;
    wire         selIrq   = avs_address == ATSS_IDX_IRQFLAG;
    wire         selRes   = avs_address == ATSS_IDX_RESULT;
    wire         selTherm = avs_address == ATSS_IDX_THERMAL;
    wire         selCnt   = avs_address == ATSS_IDX_CHGCOUNT;
    // R10 shared control register
    wire         wrCtrl   = wrLane & selCtrl;
    wire         wrCnt    = wrLane & selCnt;

    // R14 end flag, R12 busy, R11 charging, R13 enable
    wire  [7:0]  ctrlRd   = {convEnd_r, 1'b0, state_r == ST_CHARGE,
                             touchRun_r, tkEn_r, 2'b00, goBit_r};
    wire  [31:0] rdMux    =
        selCfg   ? {24'h00_0000, cfg_r}                    :
        selChan  ? {28'h000_0000, chan_r}                  :
        selCtrl  ? {24'h00_0000, ctrlRd}                   :
        selIrq   ? {24'h00_0000, irqFlag_r, 7'h00}         :
        selRes   ? {20'h0_0000, result_r}                  :
        selTherm ? {24'h00_0000, therm_r, 7'h00}           :
                   32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////
    // converter clock divider
    // R4 divider scales system clock
    wire  [2:0]  divisor  = (cfg_r.clkDiv == 2'b00) ? ATSS_DIV_ZERO_AS
                                                    : {1'b0, cfg_r.clkDiv};
    wire         adcPhase = state_r inside {ST_SAMPLE, ST_CONV, ST_GAP};
    wire         tick     = adcPhase & (divCnt_r == divisor - 3'h1);
    wire         step     = adcPhase ? tick
                                     : (state_r inside {ST_CHARGE, ST_DISCH});
    wire         last     = step & (phCnt_r == 8'h01);
    wire         done     = (state_r == ST_CONV) & last;

    // R16 discharge length from charge count
    wire  [7:0]  dischLen = (chgCnt_r >= ATSS_CHG_LONG_AT) ? ATSS_DISCH_LONG
                                                           : ATSS_DISCH_SHORT;
    // R15 charge count, zero treated as one clock
    wire  [7:0]  chgLen   = (chgCnt_r == 8'h00) ? 8'h01 : chgCnt_r;

    ////////////////////////////////////////////////////////////////////////
    // sequencer next state
    always_comb begin
        stateNxt = state_r;
        phCntNxt = step ? phCnt_r - 8'h01 : phCnt_r;
        unique case (state_r)
            ST_IDLE: begin
                // R17 count write launches touch run
                if (touchPend_r && tkEn_r) begin
                    stateNxt = ST_CHARGE;
                    phCntNxt = chgLen;
                // R1 start bit launches conversion
                end else if (goBit_r) begin
                    stateNxt = ST_SAMPLE;
                    phCntNxt = ATSS_SAMPLE_CLKS;
                end
            end
            // R23 charge, then discharge, then convert
            ST_CHARGE: begin
                if (last) begin
                    stateNxt = ST_DISCH;
                    phCntNxt = dischLen;
                end
            end
            ST_DISCH: begin
                if (last) begin
                    stateNxt = ST_SAMPLE;
                    phCntNxt = ATSS_SAMPLE_CLKS;
                end
            end
            // R2 four sample clocks, twelve conversion clocks
            ST_SAMPLE: begin
                if (last) begin
                    stateNxt = ST_CONV;
                    phCntNxt = ATSS_CONV_CLKS;
                end
            end
            ST_CONV: begin
                if (last) begin
                    stateNxt = ST_GAP;
                    phCntNxt = ATSS_GAP_CLKS;
                end
            end
            // R3 one converter clock before next start
            ST_GAP: begin
                // go already pending and no touch run waiting: next sample follows the gap at once
                if (last && goBit_r && !(touchPend_r && tkEn_r)) begin
                    stateNxt = ST_SAMPLE;
                    phCntNxt = ATSS_SAMPLE_CLKS;
                end else if (last) begin
                    stateNxt = ST_IDLE;
                end
            end
        endcase
    end

    // R1 go bit set by write, cleared at done
    assign goNxt = (wrCtrl && wByte[ATSS_BIT_GO]) ? 1'b1 :
                   done                           ? 1'b0 : goBit_r;

    ////////////////////////////////////////////////////////////////////////
    // analog routing
    // R5 R6 differential pairs; R9 temperature channel
    always_comb begin
        anaNxt            = '0;
        anaNxt.diffSel    = cfg_r.diffSel;
        anaNxt.posSel     = chan_r;
        anaNxt.negSel     = ATSS_AIN_ZERO;
        if (cfg_r.diffSel) begin
            anaNxt.posSel = chan_r[0] ? ATSS_AIN_ONE : ATSS_AIN_ZERO;
            anaNxt.negSel = chan_r[0] ? ATSS_AIN_THREE : ATSS_AIN_TWO;
        end
        anaNxt.tempSel    = ~cfg_r.diffSel & (chan_r == ATSS_CH_TEMP);
        anaNxt.power      = cfg_r.power;
        anaNxt.bufEn      = cfg_r.bufEn;
        anaNxt.gain       = cfg_r.gain;
        anaNxt.thermPower = therm_r;
        anaNxt.sample     = stateNxt == ST_SAMPLE;
        anaNxt.convert    = stateNxt == ST_CONV;
        anaNxt.charge     = stateNxt == ST_CHARGE;
        anaNxt.discharge  = stateNxt == ST_DISCH;
    end

    ////////////////////////////////////////////////////////////////////////
    // bus handshake: one wait cycle per access
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            waitReq_r <= 1'b1;
            rdData_r  <= 32'h0000_0000;
        end else begin
            waitReq_r <= ~(req & waitReq_r);
            rdData_r  <= (avs_read & waitReq_r) ? rdMux : rdData_r;
        end
    end

    // software-written settings
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            cfg_r    <= ATSS_RST_CONFIG;
            chan_r   <= ATSS_RST_CHANNEL;
            therm_r  <= 1'b0;
            tkEn_r   <= 1'b0;
            chgCnt_r <= ATSS_RST_CHGCNT;
        end else begin
            if (wrLane && selCfg) cfg_r <= wByte;
            if (wrLane && selChan) chan_r <= wByte[3:0];
            if (wrLane && selTherm) therm_r <= wByte[ATSS_BIT_THPWR];
            // R13 touch enable
            if (wrCtrl) tkEn_r <= wByte[ATSS_BIT_TKPWR];
            if (wrCnt) chgCnt_r <= wByte;
        end
    end

    // sequencer and status
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            state_r     <= ST_IDLE;
            phCnt_r     <= 8'h00;
            divCnt_r    <= 3'h0;
            goBit_r     <= 1'b0;
            convEnd_r   <= 1'b0;
            touchPend_r <= 1'b0;
            touchRun_r  <= 1'b0;
        end else begin
            state_r     <= stateNxt;
            phCnt_r     <= phCntNxt;
            divCnt_r    <= (tick || !adcPhase || stateNxt != state_r)
                           ? 3'h0 : divCnt_r + 3'h1;
            goBit_r     <= goNxt;
            // R14 cleared on start, set on done
            convEnd_r   <= done | (convEnd_r & (stateNxt != ST_SAMPLE));
            touchPend_r <= (wrCnt & tkEn_r)
                         | (touchPend_r & (stateNxt != ST_CHARGE));
            // R12 busy from charge start until done
            touchRun_r  <= (stateNxt == ST_CHARGE) | (touchRun_r & ~done);
        end
    end

    // R20 R22 flag set at done, R19 control write clears it
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            irqFlag_r <= 1'b0;
        end else begin
            irqFlag_r <= done | (irqFlag_r & ~wrCtrl);
        end
    end

    // data synchroniser and result capture
    // R8 R7 12-bit result, offset code kept as delivered
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            dataSync1_r <= 12'h000;
            dataSync2_r <= 12'h000;
            result_r    <= 12'h000;
        end else begin
            dataSync1_r <= anaData;
            dataSync2_r <= dataSync1_r;
            if (done) result_r <= dataSync2_r;
        end
    end

    // front end controls
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            ana_r <= '0;
        end else begin
            ana_r <= anaNxt;
        end
    end

    assign avs_waitrequest = waitReq_r;
    assign avs_readdata    = rdData_r;
    assign anaCtrl         = ana_r;

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    logic [4:0] tickSeen_r;
    logic [3:0] sysSeen_r;
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            tickSeen_r <= 5'h00;
            sysSeen_r  <= 4'h0;
        end else begin
            tickSeen_r <= (stateNxt != state_r) ? 5'h00
                          : tickSeen_r + {4'h0, tick};
            sysSeen_r  <= (stateNxt != state_r) ? 4'h0 : sysSeen_r + 4'h1;
        end
    end

    sequence leaveSample;
        state_r == ST_SAMPLE && stateNxt == ST_CONV;
    endsequence
    sequence leaveConv;
        state_r == ST_CONV && stateNxt == ST_GAP;
    endsequence

    // R2 sample length
    a_sample_len: assert property (leaveSample |-> tickSeen_r == 5'h03) // R2
        else $error("sampling not four converter clocks");
    // R2 conversion length
    a_conv_len: assert property (leaveConv |-> tickSeen_r == 5'h0B) // R2
        else $error("conversion not twelve converter clocks");
    // R3 gap follows done
    a_gap_after: assert property (done |=> state_r == ST_GAP) // R3
        else $error("no gap after conversion");
    // R1 go bit self-clears
    a_go_clear: assert property (done && !wrCtrl |=> !goBit_r) // R1
        else $error("start bit did not clear");
    // R20 flag set on completion
    a_irq_set: assert property (done |=> irqFlag_r ##0 convEnd_r) // R20
        else $error("completion flags not set");
    // R16 discharge length
    a_disch_len: assert property (state_r == ST_DISCH && last // R16
        |-> sysSeen_r == dischLen[3:0] - 4'h1)
        else $error("discharge length wrong");
    // R23 phase order
    a_touch_order: assert property (state_r == ST_CHARGE // R23
        |=> state_r inside {ST_CHARGE, ST_DISCH})
        else $error("charge left out of order");
    // R5 differential routing
    a_diff_route: assert property (cfg_r.diffSel && chan_r == 4'h0 // R5
        && $stable(cfg_r) && $stable(chan_r)
        |=> ana_r.posSel == 4'h0 && ana_r.negSel == 4'h2)
        else $error("differential pair zero misrouted");
    // R4 tick spacing, only when the divider is above one
    a_tick_space: assert property (tick && divisor != 3'h1 // R4
        && state_r == ST_SAMPLE && stateNxt == ST_SAMPLE |=> !tick [*1])
        else $error("converter clock not divided");

endmodule : atss_sequencer

// [sim/atss_front_model.sv]
`timescale 1ns/1ps
module atss_front_model
    import atss_pkg::*;
(
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        reset,
    // controls from the sequencer
    input  wire atss_ana_s   anaCtrl,
    // converted value towards the sequencer
    output logic      [11:0] anaData
);

    ////////////////////////////////////////////////////////////////////////
    logic [11:0] level;
    logic        active;

    // routed input level, temperature code is an arbitrary value
    // routing and offset code
    assign level  = anaCtrl.tempSel ? 12'h5A5
                  : anaCtrl.diffSel ? 12'h800 + {4'h0, anaCtrl.posSel, 4'h0}
                                      - {8'h00, anaCtrl.negSel}
                  : {8'h30, anaCtrl.posSel};
    assign active = anaCtrl.power && (anaCtrl.sample || anaCtrl.convert);

    ////////////////////////////////////////////////////////////////////////
    // value holds only while powered and sampling or converting, otherwise it keeps toggling
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            anaData <= 12'h000;
        end else if (active) begin
            anaData <= level;
        end else begin
            anaData <= ~anaData;
        end
    end

endmodule : atss_front_model

// [sim/tb_adc_touch_sense_sequencer.sv]
`timescale 1ns/1ps
module tb_adc_touch_sense_sequencer
    import atss_pkg::*;
;
    logic        clk_sys, reset, avs_read, avs_write, avs_waitrequest;
    logic [31:0] avs_address, avs_writedata, avs_readdata;
    logic [3:0]  avs_byteenable, ph, prevPh;
    logic [11:0] anaData;
    atss_ana_s   anaCtrl;
    int          n_fail, n_checks, idleRun, gapLen;
    int          run [4];
    int          len [4];
    logic        disBefore;
    logic [4:0]  fe;
    logic [9:0]  route;
    logic [7:0]  cfgTab [6] = '{8'h63, 8'hA3, 8'hE3, 8'h67, 8'h67, 8'h23};
    logic [3:0]  chTab  [6] = '{4'h5, 4'h5, 4'h5, 4'h0, 4'h1, 4'hF};
    logic [11:0] resTab [6] = '{12'h305, 12'h305, 12'h305, 12'h7FE,
                                12'h80D, 12'h5A5};
    logic [9:0]  rtTab  [6] = '{10'h140, 10'h140, 10'h140, 10'h00A,
                                10'h04E, 10'h001};
    logic [9:0]  mskTab [6] = '{10'h3C3, 10'h3C3, 10'h3C3, 10'h3FF,
                                10'h3FF, 10'h003};
    logic [7:0]  cntTab [3] = '{8'h10, 8'h7F, 8'h80};

    ////////////////////////////////////////////////////////////////////////
    atss_sequencer i_dut (
        .clk_sys(clk_sys), .reset(reset), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .anaData(anaData), .anaCtrl(anaCtrl));

    atss_front_model i_front (
        .clk_sys(clk_sys), .reset(reset), .anaCtrl(anaCtrl),
        .anaData(anaData));

    // clock of 100 ns period
    always #50 clk_sys = ~clk_sys;

    ////////////////////////////////////////////////////////////////////////
    // phase length, idle gap and routing monitor
    assign ph = {anaCtrl.convert, anaCtrl.sample, anaCtrl.discharge,
                 anaCtrl.charge};
    always @(posedge clk_sys) begin
        for (int i = 0; i < 4; i++) begin
            if (ph[i]) begin
                run[i] <= run[i] + 1;
            end else if (run[i] != 0) begin
                len[i] <= run[i];
                run[i] <= 0;
            end
        end
        if (ph == 4'h0) begin
            idleRun <= idleRun + 1;
        end else begin
            if (idleRun != 0) gapLen <= idleRun;
            idleRun <= 0;
        end
        if (ph[2] && !prevPh[2]) begin
            disBefore <= prevPh[1];
            fe        <= {anaCtrl.thermPower, anaCtrl.gain, anaCtrl.bufEn,
                          anaCtrl.power};
            route     <= {anaCtrl.posSel, anaCtrl.negSel, anaCtrl.diffSel,
                          anaCtrl.tempSel};
        end
        prevPh <= ph;
    end

    ////////////////////////////////////////////////////////////////////////
    // compare and bus tasks
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic busOp(input logic wr, input logic [31:0] a,
                         input logic [7:0] d, output logic [31:0] v);
        @(posedge clk_sys);
        avs_address   <= a;
        avs_writedata <= {24'h000000, d};
        avs_write     <= wr;
        avs_read      <= !wr;
        do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
        v = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask : busOp

    task automatic wr(input logic [31:0] a, input logic [7:0] d);
        logic [31:0] v;
        busOp(1'b1, a, d, v);
    endtask : wr

    task automatic rdChk(input logic [31:0] a, input logic [31:0] m,
                         input logic [31:0] e, input string nm);
        logic [31:0] v;
        busOp(1'b0, a, 8'h00, v);
        chk(nm, e, v & m);
    endtask : rdChk

    task automatic pollClear(input logic [31:0] a, input int b);
        logic [31:0] v;
        int          n;
        n = 0;
        do begin
            busOp(1'b0, a, 8'h00, v);
            n++;
        end while (v[b] !== 1'b0 && n < 500);
        chk("poll bit", 32'h0, {31'h0, v[b]});
    endtask : pollClear

    task automatic startConv(input logic [7:0] cfg, input logic [3:0] ch);
        wr(ATSS_IDX_CONFIG, cfg);
        wr(ATSS_IDX_CHANNEL, {4'h0, ch});
        wr(ATSS_IDX_CONTROL, 8'h01);
    endtask : startConv

    task automatic finishConv(input logic [7:0] cfg, input logic [11:0] res);
        int d;
        d = (cfg[7:6] == 2'b00) ? 4 : int'(cfg[7:6]);
        pollClear(ATSS_IDX_CONTROL, ATSS_BIT_GO);
        rdChk(ATSS_IDX_CONTROL, 32'h81, 32'h80, "end status");
        rdChk(ATSS_IDX_RESULT, 32'hFFF, {20'h0, res}, "result");
        rdChk(ATSS_IDX_IRQFLAG, 32'hFF, 32'h80, "irq set");
        chk("sample length", 4 * d, len[2]);
        chk("convert length", 12 * d, len[3]);
        chk("front setup", {27'h0, 1'b1, cfg[5:4], cfg[1:0]},
            {27'h0, fe});
        wr(ATSS_IDX_CONTROL, 8'h00);
        rdChk(ATSS_IDX_IRQFLAG, 32'hFF, 32'h00, "irq clear");
    endtask : finishConv

    task automatic final_report;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : final_report

    ////////////////////////////////////////////////////////////////////////
    // watchdog against a hung handshake or poll
    initial begin
        repeat (40000) @(posedge clk_sys);
        n_fail++;
        final_report();
    end

    // main sequence
    initial begin
        clk_sys = 1'b0; reset = 1'b1; avs_read = 1'b0; avs_write = 1'b0;
        avs_address = 32'h0; avs_writedata = 32'h0; avs_byteenable = 4'hF;
        repeat (6) @(posedge clk_sys);
        reset <= 1'b0;
        rdChk(ATSS_IDX_CONTROL, 32'hFF, 32'h00, "control reset");
        rdChk(ATSS_IDX_CHGCOUNT, 32'hFF, 32'h00, "count reads");
        rdChk(ATSS_IDX_IRQFLAG, 32'hFF, 32'h00, "irq reset");
        rdChk(ATSS_IDX_CONFIG, 32'hFF, {24'h0, ATSS_RST_CONFIG}, "config");
        rdChk(32'h4000_1060, 32'hFFFFFFFF, 32'h0, "unmapped");
        $display("test reset values done");
        wr(ATSS_IDX_THERMAL, 8'h80);
        for (int k = 0; k < 6; k++) begin
            startConv(cfgTab[k], chTab[k]);
            rdChk(ATSS_IDX_CONTROL, 32'h81, 32'h01, "go busy");
            finishConv(cfgTab[k], resTab[k]);
            chk("routing", rtTab[k] & mskTab[k], route & mskTab[k]);
            $display("test conversion %0d done", k);
        end
        startConv(8'h23, 4'h5);
        while (anaCtrl.convert !== 1'b1) @(negedge clk_sys);
        while (anaCtrl.convert !== 1'b0) @(negedge clk_sys);
        wr(ATSS_IDX_CONTROL, 8'h01);
        finishConv(8'h23, 12'h305);
        chk("gap length", 32'h4, gapLen);
        $display("test back to back done");
        wr(ATSS_IDX_CONFIG, 8'h63);
        wr(ATSS_IDX_CHANNEL, 8'h05);
        wr(ATSS_IDX_CHGCOUNT, 8'h20);
        rdChk(ATSS_IDX_CONTROL, 32'h30, 32'h00, "touch off");
        for (int k = 0; k < 3; k++) begin
            wr(ATSS_IDX_CONTROL, 8'h08);
            rdChk(ATSS_IDX_IRQFLAG, 32'hFF, 32'h00, "irq clr");
            rdChk(ATSS_IDX_CONTROL, 32'h08, 32'h08, "touch en");
            wr(ATSS_IDX_CHGCOUNT, cntTab[k]);
            rdChk(ATSS_IDX_CONTROL, 32'h38, 32'h38, "charging");
            pollClear(ATSS_IDX_CONTROL, ATSS_BIT_BUSY);
            chk("charge length", {24'h0, cntTab[k]}, len[0]);
            chk("disch length", (cntTab[k] < 8'h80) ? 8 : 14, len[1]);
            chk("phase order", 32'h1, {31'h0, disBefore});
            rdChk(ATSS_IDX_RESULT, 32'hFFF, 32'h305, "touch res");
            rdChk(ATSS_IDX_IRQFLAG, 32'hFF, 32'h80, "touch irq");
            rdChk(ATSS_IDX_CONTROL, 32'h31, 32'h00, "idle");
            $display("test touch %0d done", k);
        end
        final_report();
    end

endmodule : tb_adc_touch_sense_sequencer
